// [drsm_defs.svh]
// Constants for the drive power state machine and restore object
`ifndef DRSM_DEFS_SVH
`define DRSM_DEFS_SVH

// =====================================================================
// Object indexes and subindexes
`define DRSM_IDX_RESTORE 16'h1011
`define DRSM_IDX_CTRL 16'h6040
`define DRSM_IDX_STAT 16'h6041
`define DRSM_SUB_COUNT 8'h00
`define DRSM_SUB_ALL 8'h01
`define DRSM_SUB_COMM 8'h02
`define DRSM_SUB_PROFILE 8'h03
`define DRSM_SUB_SUPPLIER 8'h04
`define DRSM_RESTORE_ENTRIES 32'h0000_0004
`define DRSM_RESTORE_KEY 32'h6461_6f6c
`define DRSM_RESTORE_DONE 32'h0000_0001
`define DRSM_RESTORE_IDLE 32'h0000_0000

// =====================================================================
// Control word commands
`define DRSM_CW_DISABLE 16'h0000
`define DRSM_CW_QSTOP 16'h0002
`define DRSM_CW_SHUTDOWN 16'h0006
`define DRSM_CW_SWITCH_ON 16'h0007
`define DRSM_CW_ENABLE 16'h000f
`define DRSM_CW_FAULT_RST 16'h0080

// =====================================================================
// Status word values
`define DRSM_SW_INIT 16'h0000
`define DRSM_SW_FAULTLESS 16'h0250
`define DRSM_SW_READY 16'h0231
`define DRSM_SW_WAIT_EN 16'h0233
`define DRSM_SW_RUN 16'h0237
`define DRSM_SW_QSTOP 16'h0217
`define DRSM_SW_FREACT 16'h021f
`define DRSM_SW_FAULT 16'h0218
`define DRSM_SW_HOMED 16'h1000
`define DRSM_SW_ZERO 16'h0000

`endif

// [drsm_pkg.sv]
// Types shared by the drive power state machine
`default_nettype none
package drsm_pkg;
    // =================================================================
    // Power states
    typedef enum logic [2:0] {
        DRSM_INIT,
        DRSM_FAULTLESS,
        DRSM_READY,
        DRSM_WAIT_EN,
        DRSM_RUN,
        DRSM_QSTOP,
        DRSM_FREACT,
        DRSM_FAULT
    } drsm_state_t;
endpackage
`default_nettype wire

// [drsm_top.sv]
// Drive power state machine with control/status words and restore object
// What this block does
// - After reset: initialization, brake held, axis off, status 0x0000.
// - Init done goes to faultless (0x0250); a fault takes the reaction path.
// - Only running drives the motor; every other state keeps the axis off.
// - Non-automatic steps happen only on a control word write.
// - Word 0x0006 in faultless, waiting or running goes to ready (0x0231).
// - Word 0x0000 in ready, waiting or running goes to faultless (0x0250).
// - A fault enters reaction (0x021F, axis off), then fault (0x0218).
// - Fault stays until word 0x80, then goes to faultless (0x0250).
// - After enable the master homes; the status word reports homing done.
// - While a command runs, actual position and velocity are returned.
// - Restore subindex 1 all, 2 comm, 3 profile, 4 supplier parameters.
// - Only key 0x64616f6c written to a restore subindex resets its group.
// - Once that reset is saved, reading the subindex returns 1.
`timescale 1ns/100ps
`default_nettype none
`include "drsm_defs.svh"

module drsm_top (
    input wire logic sys_clk,
    input wire logic srst,
    // Object access port from the fieldbus side
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic [31:0] obj_wdata,
    output logic [31:0] obj_rdata,
    output logic obj_ack,
    output logic obj_err,
    // Drive core events
    input wire logic init_done,
    input wire logic fault,
    input wire logic fault_react_done,
    input wire logic qstop_done,
    input wire logic homing_done,
    input wire logic cmd_active,
    input wire logic [31:0] act_position,
    input wire logic [31:0] act_velocity,
    input wire logic [3:0] restore_saved,
    // Drive core controls
    output logic axis_enable,
    output logic brake_hold,
    output logic [15:0] status_word,
    output logic [3:0] restore_req,
    output logic [31:0] fb_position,
    output logic [31:0] fb_velocity,
    output var drsm_pkg::drsm_state_t drive_state
);
    import drsm_pkg::*;

    // =================================================================
    // Object decode
    drsm_state_t state;
    drsm_state_t next_state;
    logic [15:0] control_word;
    logic [3:0] saved;
    logic homed;
    logic [15:0] next_status;
    logic [31:0] next_rdata;

    // Restore subindex to one-hot group select
    function automatic logic [3:0] grp_sel(input logic [7:0] sub);
        grp_sel = {sub == `DRSM_SUB_SUPPLIER, sub == `DRSM_SUB_PROFILE,
                   sub == `DRSM_SUB_COMM, sub == `DRSM_SUB_ALL};
    endfunction

    wire acc = obj_wr | obj_rd;
    wire hit_rst = obj_index == `DRSM_IDX_RESTORE;
    wire hit_ctrl = obj_index == `DRSM_IDX_CTRL;
    wire hit_stat = obj_index == `DRSM_IDX_STAT;
    wire [3:0] sel = grp_sel(obj_sub);
    wire rst_sub = hit_rst & ((|sel) | (obj_sub == `DRSM_SUB_COUNT));
    // Status word is read-only, so a write to it is refused
    wire mapped = (hit_rst & rst_sub) | hit_ctrl | (hit_stat & obj_rd);
    wire cw_wr = obj_wr & hit_ctrl & ~obj_rd;
    wire [15:0] cw = obj_wdata[15:0];
    wire key_ok = obj_wdata == `DRSM_RESTORE_KEY;
    wire [3:0] rst_fire = (obj_wr & hit_rst & key_ok) ? sel : 4'h0;
    wire [3:0] sel_saved = sel & saved;

    // =================================================================
    // Next state: a fault first, then per-state steps; in quick stop a command outranks its exit
    always_comb begin
        next_state = state;
        if (fault && state != DRSM_FREACT && state != DRSM_FAULT) begin
            next_state = DRSM_FREACT;
        end else begin
            case (state)
                DRSM_INIT: begin
                    if (init_done) begin
                        next_state = DRSM_FAULTLESS;
                    end
                end
                DRSM_FAULTLESS: begin
                    if (cw_wr && cw == `DRSM_CW_SHUTDOWN) begin
                        next_state = DRSM_READY;
                    end
                end
                DRSM_READY: begin
                    if (cw_wr && cw == `DRSM_CW_SWITCH_ON) begin
                        next_state = DRSM_WAIT_EN;
                    end else if (cw_wr && cw == `DRSM_CW_DISABLE) begin
                        next_state = DRSM_FAULTLESS;
                    end
                end
                DRSM_WAIT_EN: begin
                    if (cw_wr && cw == `DRSM_CW_ENABLE) begin
                        next_state = DRSM_RUN;
                    end else if (cw_wr && cw == `DRSM_CW_SHUTDOWN) begin
                        next_state = DRSM_READY;
                    end else if (cw_wr && cw == `DRSM_CW_DISABLE) begin
                        next_state = DRSM_FAULTLESS;
                    end
                end
                DRSM_RUN: begin
                    if (cw_wr && cw == `DRSM_CW_SWITCH_ON) begin
                        next_state = DRSM_WAIT_EN;
                    end else if (cw_wr && cw == `DRSM_CW_SHUTDOWN) begin
                        next_state = DRSM_READY;
                    end else if (cw_wr && cw == `DRSM_CW_DISABLE) begin
                        next_state = DRSM_FAULTLESS;
                    end else if (cw_wr && cw == `DRSM_CW_QSTOP) begin
                        next_state = DRSM_QSTOP;
                    end
                end
                DRSM_QSTOP: begin
                    // A master command outranks the automatic exit
                    if (cw_wr && cw == `DRSM_CW_ENABLE) begin
                        next_state = DRSM_RUN;
                    end else if (qstop_done) begin
                        next_state = DRSM_FAULTLESS;
                    end
                end
                DRSM_FREACT: begin
                    if (fault_react_done) begin
                        next_state = DRSM_FAULT;
                    end
                end
                DRSM_FAULT: begin
                    if (cw_wr && cw == `DRSM_CW_FAULT_RST) begin
                        next_state = DRSM_FAULTLESS;
                    end
                end
                default: next_state = DRSM_INIT;
            endcase
        end
    end

    // Status word per state; homed flag only while running
    always_comb begin
        case (next_state)
            DRSM_INIT: next_status = `DRSM_SW_INIT;
            DRSM_FAULTLESS: next_status = `DRSM_SW_FAULTLESS;
            DRSM_READY: next_status = `DRSM_SW_READY;
            DRSM_WAIT_EN: next_status = `DRSM_SW_WAIT_EN;
            DRSM_RUN: next_status = (homed | homing_done) ?
                (`DRSM_SW_RUN | `DRSM_SW_HOMED) : `DRSM_SW_RUN;
            DRSM_QSTOP: next_status = `DRSM_SW_QSTOP;
            DRSM_FREACT: next_status = `DRSM_SW_FREACT;
            DRSM_FAULT: next_status = `DRSM_SW_FAULT;
            default: next_status = `DRSM_SW_INIT;
        endcase
    end

    // Read data mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            next_rdata = {16'h0000, control_word};
        end else if (hit_stat) begin
            next_rdata = {16'h0000, status_word};
        end else if (hit_rst && obj_sub == `DRSM_SUB_COUNT) begin
            next_rdata = `DRSM_RESTORE_ENTRIES;
        end else if (hit_rst && (|sel_saved)) begin
            next_rdata = `DRSM_RESTORE_DONE;
        end
    end

    // =================================================================
    // State, status and drive outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= DRSM_INIT;
            status_word <= `DRSM_SW_INIT;
            axis_enable <= 1'b0;
            brake_hold <= 1'b1;
            homed <= 1'b0;
        end else begin
            state <= next_state;
            status_word <= next_status;
            axis_enable <= next_state == DRSM_RUN;
            brake_hold <= next_state != DRSM_RUN;
            homed <= (next_state == DRSM_RUN) & (homed | homing_done);
        end
    end

    // Control word storage and monitoring feedback
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            control_word <= `DRSM_CW_DISABLE;
            fb_position <= 32'h0000_0000;
            fb_velocity <= 32'h0000_0000;
        end else begin
            if (cw_wr) begin
                control_word <= cw;
            end
            // Holds last values when idle so the master sees the stop point
            if (cmd_active) begin
                fb_position <= act_position;
                fb_velocity <= act_velocity;
            end
        end
    end

    // Restore requests; a save landing with a new trigger still counts
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            restore_req <= 4'h0;
            saved <= 4'h0;
        end else begin
            restore_req <= rst_fire;
            saved <= (saved & ~rst_fire) | restore_saved;
        end
    end

    // Access answer, one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            obj_ack <= 1'b0;
            obj_err <= 1'b0;
            obj_rdata <= 32'h0000_0000;
        end else begin
            obj_ack <= acc;
            obj_err <= acc & ~mapped;
            if (obj_rd) begin
                obj_rdata <= next_rdata;
            end
        end
    end

    assign drive_state = state;

    // =================================================================
    // Checks
    sequence cw_cmd(logic [15:0] v);
        cw_wr && cw == v && !fault;
    endsequence

    init_entry_a: assert property (@(posedge sys_clk)
        srst |=> status_word == `DRSM_SW_INIT && brake_hold && !axis_enable)
        else $error("reset did not enter initialization");

    init_exit_a: assert property (@(posedge sys_clk) disable iff (srst)
        state == DRSM_INIT && init_done && !fault
        |=> state == DRSM_FAULTLESS && status_word == `DRSM_SW_FAULTLESS)
        else $error("initialization did not reach faultless");

    axis_run_a: assert property (@(posedge sys_clk) disable iff (srst)
        axis_enable == (state == DRSM_RUN))
        else $error("axis enabled outside running");

    no_self_a: assert property (@(posedge sys_clk) disable iff (srst)
        !cw_wr && !fault && state inside {DRSM_FAULTLESS, DRSM_READY,
        DRSM_WAIT_EN, DRSM_RUN, DRSM_FAULT} |=> $stable(state))
        else $error("state changed without control word");

    to_ready_a: assert property (@(posedge sys_clk) disable iff (srst)
        state inside {DRSM_FAULTLESS, DRSM_WAIT_EN, DRSM_RUN}
        ##0 cw_cmd(`DRSM_CW_SHUTDOWN)
        |=> state == DRSM_READY && status_word == `DRSM_SW_READY)
        else $error("shutdown did not reach ready");

    to_wait_a: assert property (@(posedge sys_clk) disable iff (srst)
        state inside {DRSM_READY, DRSM_RUN} ##0 cw_cmd(`DRSM_CW_SWITCH_ON)
        |=> status_word == `DRSM_SW_WAIT_EN)
        else $error("switch on did not reach waiting to enable");

    to_run_a: assert property (@(posedge sys_clk) disable iff (srst)
        state == DRSM_WAIT_EN ##0 cw_cmd(`DRSM_CW_ENABLE)
        |=> axis_enable && (status_word & ~`DRSM_SW_HOMED) == `DRSM_SW_RUN)
        else $error("enable did not start running");

    to_fless_a: assert property (@(posedge sys_clk) disable iff (srst)
        state inside {DRSM_READY, DRSM_WAIT_EN, DRSM_RUN}
        ##0 cw_cmd(`DRSM_CW_DISABLE) |=> status_word == `DRSM_SW_FAULTLESS)
        else $error("disable did not reach faultless");

    // Reaction step and fault step checked apart, each one edge long
    sequence freact_seen;
        status_word == `DRSM_SW_FREACT && !axis_enable;
    endsequence

    fault_path_a: assert property (@(posedge sys_clk) disable iff (srst)
        fault && state != DRSM_FAULT && state != DRSM_FREACT
        |=> freact_seen)
        else $error("fault reaction not entered");

    fault_done_a: assert property (@(posedge sys_clk) disable iff (srst)
        state == DRSM_FREACT && fault_react_done
        |=> status_word == `DRSM_SW_FAULT && !axis_enable)
        else $error("fault state not reached");

    fault_clr_a: assert property (@(posedge sys_clk) disable iff (srst)
        state == DRSM_FAULT ##0 cw_cmd(`DRSM_CW_FAULT_RST)
        |=> status_word == `DRSM_SW_FAULTLESS)
        else $error("fault reset did not reach faultless");

    qstop_a: assert property (@(posedge sys_clk) disable iff (srst)
        state == DRSM_RUN ##0 cw_cmd(`DRSM_CW_QSTOP)
        |=> status_word == `DRSM_SW_QSTOP && !axis_enable)
        else $error("quick stop not entered");

    qstop_exit_a: assert property (@(posedge sys_clk) disable iff (srst)
        state == DRSM_QSTOP && qstop_done && !fault
        && !(cw_wr && cw == `DRSM_CW_ENABLE)
        |=> status_word == `DRSM_SW_FAULTLESS)
        else $error("quick stop did not end in faultless");

    qstop_back_a: assert property (@(posedge sys_clk) disable iff (srst)
        state == DRSM_QSTOP ##0 cw_cmd(`DRSM_CW_ENABLE)
        |=> axis_enable && (status_word & ~`DRSM_SW_HOMED) == `DRSM_SW_RUN)
        else $error("quick stop did not return to running");

    homed_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        state == DRSM_RUN && homing_done && !fault && !cw_wr
        |=> status_word == (`DRSM_SW_RUN | `DRSM_SW_HOMED))
        else $error("homing completion not reported");

    fb_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
        cmd_active |=> fb_position == $past(act_position)
        && fb_velocity == $past(act_velocity))
        else $error("feedback not returned");

    key_only_a: assert property (@(posedge sys_clk) disable iff (srst)
        restore_req != 4'h0 |-> $past(obj_wr) && $past(hit_rst)
        && $past(obj_wdata) == `DRSM_RESTORE_KEY)
        else $error("restore without key");

    saved_read_a: assert property (@(posedge sys_clk) disable iff (srst)
        obj_rd && hit_rst && (|sel_saved)
        |=> obj_ack && obj_rdata == `DRSM_RESTORE_DONE)
        else $error("saved restore did not read one");
endmodule
`default_nettype wire

// [drsm_master.sv]
// Fieldbus master model driving the object port of the drive block
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Master side of the object port
module drsm_master (
    input wire logic sys_clk,
    output logic obj_wr,
    output logic obj_rd,
    output logic [15:0] obj_index,
    output logic [7:0] obj_sub,
    output logic [31:0] obj_wdata,
    input wire logic [31:0] obj_rdata,
    input wire logic obj_ack,
    input wire logic obj_err
);
    // Idle port, no strobe
    initial begin
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_index = 16'h0000;
        obj_sub = 8'h00;
        obj_wdata = 32'h0000_0000;
    end

    // One access; address and data are inverted once released so a
    // late sampler sees garbage rather than a stale copy
    task automatic access(input logic w, input logic [15:0] idx,
        input logic [7:0] sub, input logic [31:0] d,
        output logic [31:0] q, output logic ack, output logic err);
        @(negedge sys_clk);
        obj_wr = w;
        obj_rd = !w;
        obj_index = idx;
        obj_sub = sub;
        obj_wdata = d;
        @(negedge sys_clk);
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_index = ~idx;
        obj_sub = ~sub;
        obj_wdata = ~d;
        q = obj_rdata;
        ack = obj_ack;
        err = obj_err;
    endtask
endmodule
`default_nettype wire

// [drsm_top_test.sv]
// Self-checking bench for the drive power state machine
`timescale 1ns/100ps
`default_nettype none
`include "drsm_defs.svh"

module drsm_top_test;
    import drsm_pkg::*;
    logic sys_clk, srst, obj_wr, obj_rd, obj_ack, obj_err, ack, err;
    logic axis_enable, brake_hold, cmd_active;
    logic [15:0] obj_index, status_word;
    logic [7:0] obj_sub;
    logic [31:0] obj_wdata, obj_rdata, q, act_position, act_velocity;
    logic [31:0] fb_position, fb_velocity, pos_keep;
    logic [3:0] restore_saved, restore_req;
    logic [4:0] ev;
    drsm_state_t drive_state;
    int n_mismatch = 0;
    int compares = 0;
    int ms, k;
    bit mhomed;
    logic [15:0] sw_tbl [8] = '{`DRSM_SW_INIT, `DRSM_SW_FAULTLESS,
        `DRSM_SW_READY, `DRSM_SW_WAIT_EN, `DRSM_SW_RUN, `DRSM_SW_QSTOP,
        `DRSM_SW_FREACT, `DRSM_SW_FAULT};
    logic [15:0] cw_list [6] = '{16'h0000, 16'h0002, 16'h0006, 16'h0007,
        16'h000f, 16'h0080};

    drsm_top drsm_top_inst (.sys_clk(sys_clk), .srst(srst),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index),
        .obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
        .obj_ack(obj_ack), .obj_err(obj_err), .init_done(ev[0]),
        .fault(ev[1]), .fault_react_done(ev[2]), .qstop_done(ev[3]),
        .homing_done(ev[4]), .cmd_active(cmd_active),
        .act_position(act_position), .act_velocity(act_velocity),
        .restore_saved(restore_saved), .axis_enable(axis_enable),
        .brake_hold(brake_hold), .status_word(status_word),
        .restore_req(restore_req), .fb_position(fb_position),
        .fb_velocity(fb_velocity), .drive_state(drive_state));
    drsm_master drsm_master_inst (.sys_clk(sys_clk), .obj_wr(obj_wr),
        .obj_rd(obj_rd), .obj_index(obj_index), .obj_sub(obj_sub),
        .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
        .obj_err(obj_err));

    // =================================================================
    // Reference model: state numbers follow the enum order
    function automatic int nxt_cw(int s, logic [15:0] cw);
        if (cw == 16'h0006 && (s == 1 || s == 3 || s == 4)) return 2;
        if (cw == 16'h0007 && (s == 2 || s == 4)) return 3;
        if (cw == 16'h000f && (s == 3 || s == 5)) return 4;
        if (cw == 16'h0000 && s >= 2 && s <= 4) return 1;
        if (cw == 16'h0002 && s == 4) return 5;
        if (cw == 16'h0080 && s == 7) return 1;
        return s;
    endfunction

    // Events: 0 init, 1 fault, 2 reaction end, 3 stop end, 4 homed
    function automatic int nxt_ev(int s, int e);
        if (e == 1 && s < 6) return 6;
        if (e == 0 && s == 0) return 1;
        if (e == 2 && s == 6) return 7;
        if (e == 3 && s == 5) return 1;
        return s;
    endfunction

    function automatic logic [15:0] exp_sw();
        return sw_tbl[ms] | (mhomed ? `DRSM_SW_HOMED : 16'h0000);
    endfunction

    task automatic m_go(int n);
        if (n != 4) mhomed = 0;
        ms = n;
    endtask

    // =================================================================
    // Comparison and bus helpers
    task automatic chk(string name, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_state();
        chk("status_word", {16'h0, exp_sw()}, {16'h0, status_word});
        chk("axis_enable", 32'(ms == 4), {31'h0, axis_enable});
        chk("brake_hold", 32'(ms != 4), {31'h0, brake_hold});
        chk("drive_state", 32'(ms), {29'h0, drive_state});
    endtask

    task automatic wr(logic [15:0] idx, logic [7:0] sub, logic [31:0] d);
        drsm_master_inst.access(1'b1, idx, sub, d, q, ack, err);
        chk("obj_ack", 32'h1, {31'h0, ack});
    endtask

    task automatic rd(logic [15:0] idx, logic [7:0] sub);
        drsm_master_inst.access(1'b0, idx, sub, 32'h0, q, ack, err);
        chk("obj_ack", 32'h1, {31'h0, ack});
    endtask

    task automatic cw_write(logic [15:0] cw);
        wr(`DRSM_IDX_CTRL, 8'h00, {16'h0, cw});
        m_go(nxt_cw(ms, cw));
        chk_state();
    endtask

    task automatic pulse(int e);
        @(negedge sys_clk);
        ev[e] = 1'b1;
        @(negedge sys_clk);
        ev[e] = 1'b0;
        m_go(nxt_ev(ms, e));
        if (e == 4 && ms == 4) mhomed = 1;
        chk_state();
    endtask

    task automatic do_reset();
        @(negedge sys_clk);
        srst = 1'b1;
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        m_go(0);
        chk_state();
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // =================================================================
    // Clock, and a watchdog well beyond the expected run length
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        #(40 * 20000);
        n_mismatch++;
        final_report();
    end

    // =================================================================
    // Main sequence
    initial begin
        srst = 1'b1;
        ev = 5'h00;
        cmd_active = 1'b0;
        act_position = 32'h0;
        act_velocity = 32'h0;
        restore_saved = 4'h0;
        void'($urandom(54));
        do_reset();
        repeat (4) @(negedge sys_clk);
        chk_state();
        pulse(1);
        pulse(2);
        cw_write(16'h0006);
        cw_write(16'h0080);
        do_reset();
        pulse(0);
        // Enable only after ready is seen in the status word
        cw_write(16'h0006);
        rd(`DRSM_IDX_STAT, 8'h00);
        chk("status_read", {16'h0, `DRSM_SW_READY}, q);
        cw_write(16'h0007);
        cw_write(16'h000f);
        pulse(4);
        cw_write(16'h0007);
        cw_write(16'h000f);
        cw_write(16'h0002);
        cw_write(16'h000f);
        cw_write(16'h0002);
        pulse(3);
        // Random walk through commands and drive events
        for (int i = 0; i < 300; i++) begin
            k = $urandom_range(11);
            if (k < 6) cw_write(cw_list[k]);
            else if (k == 6) cw_write(16'($urandom));
            else pulse(k - 7);
            rd(`DRSM_IDX_STAT, 8'h00);
            chk("status_read", {16'h0, exp_sw()}, q);
        end
        cw_write(16'h0006);
        rd(`DRSM_IDX_CTRL, 8'h00);
        chk("ctrl_read", 32'h6, q);
        // Restore groups: wrong key, right key, save, read back
        for (int s = 1; s <= 4; s++) begin
            wr(`DRSM_IDX_RESTORE, 8'(s), `DRSM_RESTORE_KEY ^ 32'h1);
            chk("restore_req", 32'h0, {28'h0, restore_req});
            wr(`DRSM_IDX_RESTORE, 8'(s), `DRSM_RESTORE_KEY);
            chk("restore_req", 32'(1 << (s - 1)), {28'h0, restore_req});
            rd(`DRSM_IDX_RESTORE, 8'(s));
            chk("restore_read", 32'h0, q);
            @(negedge sys_clk);
            restore_saved = 4'(1 << (s - 1));
            @(negedge sys_clk);
            restore_saved = 4'h0;
            rd(`DRSM_IDX_RESTORE, 8'(s));
            chk("restore_read", 32'h1, q);
        end
        rd(`DRSM_IDX_RESTORE, 8'h00);
        chk("restore_count", 32'h4, q);
        // Unmapped places answer with an error and change nothing
        rd(16'h1234, 8'h00);
        chk("obj_err", 32'h1, {31'h0, err});
        rd(`DRSM_IDX_RESTORE, 8'h05);
        chk("obj_err", 32'h1, {31'h0, err});
        wr(`DRSM_IDX_STAT, 8'h00, 32'h0);
        chk("obj_err", 32'h1, {31'h0, err});
        chk_state();
        // Feedback follows actual values only while a command runs
        @(negedge sys_clk);
        cmd_active = 1'b1;
        act_position = $urandom;
        act_velocity = $urandom;
        @(negedge sys_clk);
        pos_keep = act_position;
        chk("fb_position", act_position, fb_position);
        chk("fb_velocity", act_velocity, fb_velocity);
        cmd_active = 1'b0;
        act_position = ~act_position;
        @(negedge sys_clk);
        chk("fb_position", pos_keep, fb_position);
        final_report();
    end
endmodule
`default_nettype wire
